// file: hw/psta_pkg.sv
// Purpose: Shared constants and carriers for the program space table access block
// Assumes: 24-bit program words, 16-bit data space, APB register access
// Notes:   Byte addresses of registers are word aligned

package psta_pkg;

  localparam int unsigned DATA_W      = 32;
  localparam int unsigned PWORD_W     = 24;
  localparam int unsigned OFFSET_W    = 16;
  localparam int unsigned PAGE_W      = 8;
  localparam int unsigned PAGE_CFG_BIT = 7;

  // Register byte offsets
  localparam logic [11:0] REG_PAGE    = 12'h000;
  localparam logic [11:0] REG_ADDR    = 12'h004;
  localparam logic [11:0] REG_WDATA   = 12'h008;
  localparam logic [11:0] REG_CMD     = 12'h00C;
  localparam logic [11:0] REG_RDATA   = 12'h010;
  localparam logic [11:0] REG_STATUS  = 12'h014;

  // Command register fields
  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_BYTE_BIT = 2;
  localparam int unsigned CMD_EE_BIT   = 3;

  // Operation encodings
  localparam logic [1:0] OP_READ_LOW   = 2'h0;
  localparam logic [1:0] OP_READ_HIGH  = 2'h1;
  localparam logic [1:0] OP_WRITE_LOW  = 2'h2;
  localparam logic [1:0] OP_WRITE_HIGH = 2'h3;

  // Status register fields
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_DONE_BIT    = 1;
  localparam int unsigned ST_REFUSED_BIT = 2;

  localparam logic [PAGE_W-1:0]   PAGE_RESET  = 8'h00;
  localparam logic [OFFSET_W-1:0] ADDR_RESET  = 16'h0000;
  localparam logic [15:0]         WDATA_RESET = 16'h0000;

  // Memory geometry
  localparam int unsigned PROG_AW = 10;
  localparam int unsigned EE_AW   = 7;
  localparam int unsigned CFG_AW  = 4;

  typedef struct packed {
    logic [1:0] op;
    logic       byte_mode;
    logic       eeprom;
  } psta_cmd_t;

  typedef struct packed {
    logic       refused;
    logic       done;
    logic       busy;
  } psta_status_t;

  typedef struct packed {
    logic [PAGE_W-1:0]   page;
    logic [OFFSET_W-1:0] offset;
  } psta_addr_t;

endpackage : psta_pkg

// file: hw/psta_mem.sv
// Purpose: Word memory with registered read data and byte-lane writes
// Assumes: Single clock, one access per cycle
// Notes:   Contents are not reset

`timescale 1ns/10ps
`default_nettype none

module psta_mem #(
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 24
) (
  input  wire logic           pclk,
  input  wire logic           en,
  input  wire logic           we,
  input  wire logic [DW/8-1:0] lane_we,
  input  wire logic [AW-1:0]  addr,
  input  wire logic [DW-1:0]  wdata,
  output logic      [DW-1:0]  rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge pclk) begin
    if (en) begin
      for (int i = 0; i < DW/8; i++) begin
        if (we && lane_we[i]) begin
          mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
      rdata <= mem[addr];
    end
  end

endmodule // psta_mem

`default_nettype wire

// file: hw/psta_top.sv
// Purpose: Table read and write path between 24-bit program space and 16-bit data
// Assumes: APB slave, pclk 250 MHz, presetn asynchronous active low
// Notes:   Configuration space is read-only; the identification word is a parameter
//
// Summary of operation
// - A low read or write moves the lower 16 bits of any program word directly.
// - A low read or write also moves one word of the data EEPROM array.
// - High reads and writes are the only path to the upper 8 bits of a program word.
// - Program word addresses step by two, so the word index is the offset shifted by one.
// - A word-mode low read returns program bits 15 to 0 as data bits 15 to 0.
// - A byte-mode low read returns the upper low byte when byte select is one, else the lower.
// - A word-mode high read returns program bits 23 to 16 with the upper data byte zero.
// - A byte-mode high read returns zero for byte select one, else program bits 23 to 16.
// - Every table operation works in both byte and word form.
// - The table page register supplies the upper address bit of program accesses; data EEPROM accesses use the offset alone.
// - Page bit 7 zero selects user memory and one selects configuration space.
// - Configuration space allows reads only, from implemented words such as the ID.
// - Data EEPROM word addresses are even; the lowest address bit is forced to zero.
//
// The register offsets and the APB interface to the registers were decided locally.

`timescale 1ns/10ps
`default_nettype none

module psta_top #(
  parameter logic [23:0] DEVICE_ID = 24'h00A5C3,  // Value is arbitrary
  parameter logic [23:0] DEVICE_REV = 24'h000001  // Value is arbitrary
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  typedef enum logic [3:0] {
    PSTA_IDLE  = 4'b0001,
    PSTA_ISSUE = 4'b0010,
    PSTA_WAIT  = 4'b0100,
    PSTA_DONE  = 4'b1000
  } psta_state_t;

  function automatic logic [15:0] psta_lane(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [3:0] strb);
    psta_lane = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  psta_state_t           state;
  logic [7:0]            table_page_register;
  logic [15:0]           offset;
  logic [15:0]           wdata;
  logic [15:0]           rdata;
  psta_pkg::psta_cmd_t   cmd;
  psta_pkg::psta_status_t status;

  // APB decode
  wire logic setup_w   = psel && !penable;
  wire logic access_w  = psel && penable;
  wire logic wr_w      = access_w && pwrite && pready;
  wire logic hit_page  = (paddr == psta_pkg::REG_PAGE);
  wire logic hit_addr  = (paddr == psta_pkg::REG_ADDR);
  wire logic hit_wdata = (paddr == psta_pkg::REG_WDATA);
  wire logic hit_cmd   = (paddr == psta_pkg::REG_CMD);
  wire logic hit_rdata = (paddr == psta_pkg::REG_RDATA);
  wire logic hit_stat  = (paddr == psta_pkg::REG_STATUS);
  wire logic mapped    = hit_page | hit_addr | hit_wdata | hit_cmd | hit_rdata | hit_stat;
  wire logic start_w   = wr_w && hit_cmd && !status.busy && pstrb[0];

  // Command decoding
  wire psta_pkg::psta_cmd_t new_cmd = '{op: pwdata[psta_pkg::CMD_OP_LSB +: 2],
                                        byte_mode: pwdata[psta_pkg::CMD_BYTE_BIT],
                                        eeprom: pwdata[psta_pkg::CMD_EE_BIT]};
  wire logic cfg_sel   = table_page_register[psta_pkg::PAGE_CFG_BIT];
  wire logic is_write  = cmd.op[1];
  wire logic is_high   = cmd.op[0];
  wire logic byte_sel  = offset[0];
  wire logic refuse_w  = (is_write && cfg_sel) || (cmd.eeprom && is_high);
  wire psta_pkg::psta_addr_t full_addr = '{page: table_page_register, offset: offset};
  // Page bit 0 tops the word index so that the index fills the program array exactly
  wire logic [psta_pkg::PROG_AW-1:0] prog_idx =
    {full_addr.page[0], full_addr.offset[psta_pkg::PROG_AW-1:1]};
  wire logic [15:0] ee_offset = {offset[15:1], 1'b0};
  wire logic [psta_pkg::EE_AW-1:0] ee_idx = ee_offset[psta_pkg::EE_AW:1];
  wire logic [psta_pkg::CFG_AW-1:0] cfg_idx = offset[psta_pkg::CFG_AW:1];

  // Memory strobes
  wire logic issue_w   = (state == PSTA_ISSUE) && !refuse_w;
  wire logic prog_en   = issue_w && !cmd.eeprom && !cfg_sel;
  wire logic ee_en     = issue_w && cmd.eeprom && !cfg_sel;
  // byte lanes of the program word chosen by operation and byte select
  wire logic [2:0] prog_lanes = is_high ? 3'b100 :
                                (cmd.byte_mode ? (byte_sel ? 3'b010 : 3'b001) : 3'b011);
  wire logic [1:0] ee_lanes   = cmd.byte_mode ? (byte_sel ? 2'b10 : 2'b01) : 2'b11;
  wire logic [7:0] wr_byte    = wdata[7:0];
  wire logic [23:0] prog_wdata = is_high ? {wr_byte, 16'h0000} :
                                 (cmd.byte_mode ? {wr_byte, wr_byte, wr_byte} :
                                  {8'h00, wdata});
  wire logic [15:0] ee_wdata  = cmd.byte_mode ? {wr_byte, wr_byte} : wdata;

  logic [23:0] prog_q;
  logic [15:0] ee_q;

  psta_mem #(.AW(psta_pkg::PROG_AW), .DW(psta_pkg::PWORD_W)) u_prog (
    .pclk    (pclk),
    .en      (prog_en),
    .we      (is_write),
    .lane_we (prog_lanes),
    .addr    (prog_idx),
    .wdata   (prog_wdata),
    .rdata   (prog_q)
  );

  psta_mem #(.AW(psta_pkg::EE_AW), .DW(16)) u_ee (
    .pclk    (pclk),
    .en      (ee_en),
    .we      (is_write),
    .lane_we (ee_lanes),
    .addr    (ee_idx),
    .wdata   (ee_wdata),
    .rdata   (ee_q)
  );

  // Configuration space: only identification words are implemented
  logic        cfg_seen;
  logic [23:0] cfg_q;
  wire logic [23:0] cfg_word = (cfg_idx == 4'h0) ? DEVICE_ID :
                               (cfg_idx == 4'h1) ? DEVICE_REV : 24'h000000;

  logic        src_ee;
  wire logic [23:0] src_word = cfg_seen ? cfg_q : (src_ee ? {8'h00, ee_q} : prog_q);
  wire logic [15:0] low_word = src_word[15:0];
  wire logic [7:0]  high_byte = src_word[23:16];
  wire logic [15:0] low_result = cmd.byte_mode ?
                                 {8'h00, (byte_sel ? low_word[15:8] : low_word[7:0])} :
                                 low_word;
  wire logic [15:0] high_result = (cmd.byte_mode && byte_sel) ? 16'h0000 :
                                  {8'h00, high_byte};
  wire logic [15:0] read_result = is_high ? high_result : low_result;

  // Sequencer
  psta_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      PSTA_IDLE:  next_state = start_w ? PSTA_ISSUE : PSTA_IDLE;
      PSTA_ISSUE: next_state = refuse_w ? PSTA_DONE : PSTA_WAIT;
      PSTA_WAIT:  next_state = PSTA_DONE;
      PSTA_DONE:  next_state = start_w ? PSTA_ISSUE : PSTA_IDLE;
      default:    next_state = PSTA_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PSTA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd      <= '0;
      src_ee   <= 1'b0;
      cfg_seen <= 1'b0;
      cfg_q    <= 24'h000000;
    end else if (start_w) begin
      cmd <= new_cmd;
    end else if (state == PSTA_ISSUE) begin
      src_ee   <= cmd.eeprom;
      cfg_seen <= cfg_sel;
      cfg_q    <= cfg_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 16'h0000;
    end else if (state == PSTA_WAIT && !is_write) begin
      rdata <= read_result;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (start_w) begin
      status <= '{refused: 1'b0, done: 1'b0, busy: 1'b1};
    end else if (state == PSTA_ISSUE && refuse_w) begin
      status <= '{refused: 1'b1, done: 1'b1, busy: 1'b0};
    end else if (state == PSTA_WAIT) begin
      status <= '{refused: 1'b0, done: 1'b1, busy: 1'b0};
    end
  end

  // Software registers; address and data are frozen while busy
  wire logic reg_wr_ok = wr_w && !status.busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_page_register <= psta_pkg::PAGE_RESET;
      offset              <= psta_pkg::ADDR_RESET;
      wdata               <= psta_pkg::WDATA_RESET;
    end else if (reg_wr_ok) begin
      if (hit_page && pstrb[0]) begin
        table_page_register <= pwdata[7:0];
      end
      if (hit_addr) begin
        offset <= psta_lane(offset, pwdata[15:0], pstrb);
      end
      if (hit_wdata) begin
        wdata <= psta_lane(wdata, pwdata[15:0], pstrb);
      end
    end
  end

  // APB answer: no wait state, read data registered
  wire logic [31:0] rd_mux =
    hit_page  ? {24'h000000, table_page_register} :
    hit_addr  ? {16'h0000, offset} :
    hit_wdata ? {16'h0000, wdata} :
    hit_cmd   ? {28'h0000000, cmd.eeprom, cmd.byte_mode, cmd.op} :
    hit_rdata ? {16'h0000, rdata} :
    hit_stat  ? {29'h00000000, status} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_w) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= !mapped;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // psta_top

`default_nettype wire

// file: bench/psta_chk.sv
// Purpose: Port checks for psta_top
// Assumes: Setup cycle is answered in the next cycle
// Notes:   Bound to every psta_top
`timescale 1ns/10ps
`default_nettype none
module psta_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic [3:0] cmd_q;
  wire acc = psel && penable && pready;
  wire mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014};
  wire rd_res = acc && !pwrite && paddr == psta_pkg::REG_RDATA;
  // Last accepted command, to know what the result register holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmd_q <= 4'h0;
    else if (acc && pwrite && paddr == psta_pkg::REG_CMD) cmd_q <= pwdata[3:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_hi_rd; rd_res && cmd_q[1:0] == psta_pkg::OP_READ_HIGH; endsequence
  sequence s_byte_lo; rd_res && cmd_q[1:0] == psta_pkg::OP_READ_LOW && cmd_q[2]; endsequence
  a_ready_next: assert property (s_setup |=> pready) else $error("pready late");
  a_ready_one: assert property (pready |=> !pready) else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_unmap_err: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
  a_map_ok: assert property (acc && mapped |-> !pslverr) else $error("false pslverr");
  a_write_zero: assert property (acc && pwrite |-> prdata == 32'h0) else $error("wr data");
  a_upper_zero: assert property (rd_res |-> prdata[31:16] == 16'h0000)
    else $error("upper half set");
  a_high_zero: assert property (s_hi_rd |-> prdata[15:8] == 8'h00)
    else $error("phantom byte set");
  a_byte_zero: assert property (s_byte_lo |-> prdata[15:8] == 8'h00)
    else $error("byte read upper set");
endmodule // psta_chk
bind psta_top psta_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// file: bench/psta_core.sv
// Purpose: Core model issuing table operations over APB
// Assumes: One request at a time, status polled before result
// Notes:   Released address and data lines show inverted values
`timescale 1ns/10ps
`default_nettype none
module psta_core (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // Callers keep high operations off the data EEPROM
  task automatic op(input logic [7:0] pg, input logic [15:0] ad, input logic [15:0] wd,
                    input logic [3:0] cmd, output logic [31:0] rd, output logic [31:0] st);
    logic e;
    xfer(1'b1, psta_pkg::REG_PAGE, {24'h0, pg}, rd, e);
    xfer(1'b1, psta_pkg::REG_ADDR, {16'h0, ad}, rd, e);
    xfer(1'b1, psta_pkg::REG_WDATA, {16'h0, wd}, rd, e);
    xfer(1'b1, psta_pkg::REG_CMD, {28'h0, cmd}, rd, e);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b0, psta_pkg::REG_STATUS, 32'h0, st, e);
      if (st[1:0] === 2'b10) break;
    end
    xfer(1'b0, psta_pkg::REG_RDATA, 32'h0, rd, e);
  endtask
endmodule // psta_core
`default_nettype wire

// file: bench/program_space_table_access_tb.sv
// Purpose: Self-checking bench for psta_top
// Assumes: Core model drives APB
// Notes:   Random words are stored, then read back in every mode
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin err_total++; \
  $display("[FAIL] %s exp %h seen %h", nm, ex, sn); end end
module program_space_table_access_tb;
  localparam logic [23:0] ID_V  = 24'h3C5A69; // Value is arbitrary
  localparam logic [23:0] REV_V = 24'h0000B7; // Value is arbitrary
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, b, s;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, st;
  logic [3:0]  pstrb;
  logic [23:0] w [6];
  logic [8:0]  k [6];
  logic [1:0]  pg [6];
  logic [1:0]  op;
  logic [15:0] ev, xv;
  logic [7:0]  bv;
  int          err_total, n_compared, cyc;
  int unsigned rs;
  psta_top #(.DEVICE_ID(ID_V), .DEVICE_REV(REV_V)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  psta_core u_core (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));
  function automatic logic [15:0] exp_rd(input logic [23:0] v, input logic [1:0] o,
                                         input logic bm, input logic bs);
    if (o == psta_pkg::OP_READ_LOW) return bm ? {8'h00, bs ? v[15:8] : v[7:0]} : v[15:0];
    return (bm && bs) ? 16'h0000 : {8'h00, v[23:16]};
  endfunction
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial cyc = 0;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    err_total = 0;
    n_compared = 0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rs = $urandom(67517);
    u_core.xfer(1'b0, psta_pkg::REG_PAGE, 32'h0, r, e);
    `CHK("page reset", 32'h0, r)
    u_core.xfer(1'b0, 12'h018, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    for (int i = 0; i < 6; i++) begin
      w[i] = 24'($urandom);
      // Odd entries share the offset of the one before and differ in the page only
      k[i] = (i % 2) ? k[i-1] : {6'($urandom), 3'(i)};
      pg[i] = {1'($urandom), 1'(i % 2)};
      u_core.op({6'h00, pg[i]}, {6'h00, k[i], 1'b0}, w[i][15:0], 4'h2, r, st);
      `CHK("write low", 3'b010, st[2:0])
      u_core.op({6'h00, pg[i]}, {6'h00, k[i], 1'b0}, {8'h00, w[i][23:16]}, 4'h3, r, st);
      `CHK("write high", 3'b010, st[2:0])
    end
    u_core.op(8'h80, 16'h0000, 16'h0000, 4'h0, r, st);
    `CHK("id low", ID_V[15:0], r[15:0])
    u_core.op(8'h80, 16'h0000, 16'h0000, 4'h1, r, st);
    `CHK("id high", {8'h00, ID_V[23:16]}, r[15:0])
    u_core.op(8'h80, 16'h0002, 16'h0000, 4'h0, r, st);
    `CHK("rev low", REV_V[15:0], r[15:0])
    u_core.op({6'h20, pg[0]}, {6'h00, k[0], 1'b0}, 16'h5AA5, 4'h2, r, st);
    `CHK("cfg write refused", 1'b1, st[2])
    u_core.op(8'h80, 16'h0000, 16'h0000, 4'h0, r, st);
    `CHK("id kept", ID_V[15:0], r[15:0])
    ev = 16'($urandom);
    u_core.op(8'h00, 16'h0013, ev, 4'hA, r, st);
    `CHK("ee write ok", 1'b0, st[2])
    u_core.op(8'h00, 16'h0012, 16'h0000, 4'h8, r, st);
    `CHK("ee word", ev, r[15:0])
    u_core.op(8'h00, 16'h0013, 16'h0000, 4'hC, r, st);
    `CHK("ee byte", {8'h00, ev[15:8]}, r[15:0])
    for (int i = 0; i < 6; i++) begin
      for (int m = 0; m < 6; m++) begin
        op = (m < 3) ? psta_pkg::OP_READ_LOW : psta_pkg::OP_READ_HIGH;
        b = (m % 3) != 0;
        s = (m % 3) == 2;
        u_core.op({6'h00, pg[i]}, {6'h00, k[i], s}, 16'h0000, {1'b0, b, op}, r, st);
        xv = exp_rd(w[i], op, b, s);
        if (m < 3) `CHK("read low", xv, r[15:0])
        else `CHK("read high", xv, r[15:0])
      end
    end
    bv = 8'($urandom);
    u_core.op({6'h00, pg[0]}, {6'h00, k[0], 1'b1}, {8'h00, bv}, 4'h6, r, st);
    u_core.op({6'h00, pg[0]}, {6'h00, k[0], 1'b0}, 16'h0000, 4'h0, r, st);
    `CHK("byte write low", {bv, w[0][7:0]}, r[15:0])
    u_core.op({6'h00, pg[0]}, {6'h00, k[0], 1'b0}, 16'h0000, 4'h1, r, st);
    `CHK("byte write keeps high", {8'h00, w[0][23:16]}, r[15:0])
    stop_test();
  end
endmodule // program_space_table_access_tb
`default_nettype wire
